// >>> core/sfwp_prot_map.v
// Block-protect decoder: protect code, density and map choice to a mask of 64KB blocks.
// Assumes inputs are quasi-static; the mask is registered one cycle behind them.
`timescale 1ns/1ps
`include "sfwp_regs.vh"
module sfwp_prot_map (
    input wire ref_clk_in,
    input wire reset_n_in,
    input wire [3:0] code_in,
    input wire [2:0] density_in,
    input wire alt_map_in,
    output reg [7:0] mask_out
);
    function [7:0] low_blocks;
        input [3:0] n;
        begin
            case (n)
                4'h0: low_blocks = 8'h00;
                4'h1: low_blocks = 8'h01;
                4'h2: low_blocks = 8'h03;
                4'h3: low_blocks = 8'h07;
                4'h4: low_blocks = 8'h0f;
                4'h5: low_blocks = 8'h1f;
                4'h6: low_blocks = 8'h3f;
                4'h7: low_blocks = 8'h7f;
                default: low_blocks = 8'hff;
            endcase
        end
    endfunction

    function [3:0] step4;
        input [3:0] i;
        begin
            case (i)
                4'h1: step4 = 4'h1;
                4'h2: step4 = 4'h2;
                4'h3: step4 = 4'h4;
                4'h4: step4 = 4'h6;
                4'h5: step4 = 4'h7;
                default: step4 = 4'h8;
            endcase
        end
    endfunction

    function [7:0] decode;
        input [3:0] c;
        input [2:0] dens;
        input alt;
        reg [3:0] nb;
        reg [7:0] full;
        begin
            case (dens)
                `SFWP_DENS_4M: nb = 4'h8;
                `SFWP_DENS_2M: nb = 4'h4;
                `SFWP_DENS_1M: nb = 4'h2;
                default: nb = 4'h1;
            endcase
            full = low_blocks(nb);
            decode = full;
            if (c == 4'h0 || (alt && c == 4'hf)) begin
                decode = 8'h00;
            end else if (dens == `SFWP_DENS_4M) begin
                if (c <= 4'h5)
                    decode = full & ~low_blocks(4'h8 - step4(c));
                else if (!alt && c >= 4'h9 && c <= 4'hd)
                    decode = low_blocks(step4(c - 4'h8));
                else if (alt && c >= 4'ha)
                    decode = low_blocks(step4(4'hf - c));
            end else if (dens == `SFWP_DENS_2M) begin
                if (c <= 4'h3)
                    decode = full & ~low_blocks(4'h4 - c);
                else if (!alt && c >= 4'h9 && c <= 4'hb)
                    decode = low_blocks(c - 4'h8);
                else if (alt && c >= 4'hc)
                    decode = low_blocks(4'hf - c);
            end else if (dens == `SFWP_DENS_1M) begin
                if (c == 4'h1)
                    decode = 8'h02;
                else if ((!alt && c == 4'h9) || (alt && c == 4'he))
                    decode = 8'h01;
            end
        end
    endfunction

    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mask_out <= 8'h00;
        end else begin
            mask_out <= decode(code_in, density_in, alt_map_in);
        end
    end
endmodule // sfwp_prot_map

// >>> core/sfwp_regs.vh
// Register offsets, field positions, opcodes and codes of the flash write-protect block.
// Assumes byte-addressed 32-bit Avalon-MM words and an SPI host framing bytes with chip select.
`ifndef SFWP_REGS_VH
`define SFWP_REGS_VH

`define SFWP_ADDR_CTRL 4'h0
`define SFWP_ADDR_STATUS 4'h4
`define SFWP_ADDR_LASTOP 4'h8
`define SFWP_ADDR_PROTMASK 4'hc

`define SFWP_CTRL_DENS_LSB 0
`define SFWP_CTRL_DENS_MSB 2
`define SFWP_CTRL_ALT_BIT 3
`define SFWP_CTRL_OPTC_BIT 4
`define SFWP_CTRL_RESET 5'h00

`define SFWP_ST_SWD 7
`define SFWP_ST_QEN 6
`define SFWP_ST_BP_MSB 5
`define SFWP_ST_BP_LSB 2
`define SFWP_ST_WIP 0
`define SFWP_NV_RESET 6'h00

`define SFWP_OP_WEN 8'h06
`define SFWP_OP_WRDI 8'h04
`define SFWP_OP_RDSR 8'h05
`define SFWP_OP_WSR 8'h01
`define SFWP_OP_PP 8'h02
`define SFWP_OP_PPQ_A 8'h32
`define SFWP_OP_PPQ_B 8'h38
`define SFWP_OP_SER_A 8'hd7
`define SFWP_OP_SER_B 8'h20
`define SFWP_OP_BER32 8'h52
`define SFWP_OP_BER64 8'hd8
`define SFWP_OP_CER_A 8'hc7
`define SFWP_OP_CER_B 8'h60

`define SFWP_DENS_4M 3'h0
`define SFWP_DENS_2M 3'h1
`define SFWP_DENS_1M 3'h2
`define SFWP_DENS_512K 3'h3
`define SFWP_DENS_256K 3'h4

`define SFWP_KIND_NONE 3'h0
`define SFWP_KIND_PROG 3'h1
`define SFWP_KIND_SECT 3'h2
`define SFWP_KIND_BLK32 3'h3
`define SFWP_KIND_BLK64 3'h4
`define SFWP_KIND_CHIP 3'h5

`define SFWP_WSR_BYTES 3'h2
`define SFWP_ADDR_BYTES 3'h4
`define SFWP_PROG_BYTES 3'h5

`endif

// >>> core/sfwp_spi_rx.v
// SPI byte receiver: shifts SI on SCK rising edges while chip select is low.
// Assumes SCK, SI and chip select are synchronous to the system clock and slower than it.
`timescale 1ns/1ps
module sfwp_spi_rx (
    input wire ref_clk_in,
    input wire reset_n_in,
    input wire cs_n_in,
    input wire sck_in,
    input wire si_in,
    input wire pause_in,
    output reg byte_valid_out,
    output reg [7:0] byte_out,
    output reg frame_end_out,
    output reg aligned_out,
    output reg sck_fall_out
);
    reg sck_q;
    reg cs_q;
    reg [2:0] bit_cnt;
    reg [6:0] shift;
    wire rise = !cs_n_in && sck_in && !sck_q && !pause_in;
    wire fall = !cs_n_in && !sck_in && sck_q && !pause_in;

    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sck_q <= 1'b0;
            cs_q <= 1'b1;
            bit_cnt <= 3'h0;
            shift <= 7'h00;
            byte_valid_out <= 1'b0;
            byte_out <= 8'h00;
            frame_end_out <= 1'b0;
            aligned_out <= 1'b0;
            sck_fall_out <= 1'b0;
        end else begin
            sck_q <= sck_in;
            cs_q <= cs_n_in;
            byte_valid_out <= 1'b0;
            sck_fall_out <= fall;
            frame_end_out <= cs_n_in && !cs_q;
            aligned_out <= (bit_cnt == 3'h0);
            if (cs_n_in) begin
                bit_cnt <= 3'h0;
            end else if (rise) begin
                shift <= {shift[5:0], si_in};
                bit_cnt <= bit_cnt + 3'h1;
                if (bit_cnt == 3'h7) begin
                    byte_out <= {shift, si_in};
                    byte_valid_out <= 1'b1;
                end
            end
        end
    end
endmodule // sfwp_spi_rx

// >>> core/sfwp_write_protect.v
// Write-protect logic of a serial NOR flash: status bits, latch, protect check, Avalon-MM view.
// Assumes SPI pins synchronous to ref_clk_in and an erase/program engine reporting busy.
`timescale 1ns/1ps
`include "sfwp_regs.vh"
module sfwp_write_protect (
    input wire ref_clk_in,
    input wire reset_n_in,
    input wire [3:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    input wire [3:0] avs_byteenable_in,
    output reg [31:0] avs_readdata_out,
    output reg avs_waitrequest_out,
    input wire spi_cs_n_in,
    input wire spi_sck_in,
    input wire spi_si_in,
    output reg spi_so_out,
    output reg spi_so_oe_n_out,
    input wire third_data_line_in,
    input wire fourth_data_line_in,
    input wire op_busy_in,
    output reg op_start_out,
    output reg op_reject_out,
    output reg [2:0] op_kind_out,
    output reg [23:0] op_addr_out,
    output reg quad_enable_out,
    output reg wp_function_out,
    output reg hold_function_out
);
    localparam S_IDLE = 2'd0;
    localparam S_BODY = 2'd1;
    localparam S_RDSR = 2'd2;
    localparam S_SKIP = 2'd3;

    reg [5:0] nv_bits;
    reg write_enable_latch;
    reg wip;
    reg [4:0] ctrl;
    reg [1:0] state;
    reg [2:0] byte_cnt;
    reg [7:0] cmd;
    reg [23:0] addr;
    reg [7:0] wdata;
    reg [7:0] so_shift;
    reg [23:0] last_addr;
    reg [2:0] last_kind;
    reg last_rej;
    reg [31:0] next_readdata;

    wire rx_byte_valid;
    wire [7:0] rx_byte;
    wire rx_frame_end;
    wire rx_aligned;
    wire rx_sck_fall;
    wire [7:0] prot_mask;

    wire [7:0] status_byte = {nv_bits, write_enable_latch, wip};
    wire status_write_disable = status_byte[`SFWP_ST_SWD];
    wire quad_enable = status_byte[`SFWP_ST_QEN];
    wire [3:0] protect_code = status_byte[`SFWP_ST_BP_MSB:`SFWP_ST_BP_LSB];
    wire protect_code_bit3 = protect_code[3];
    wire protect_code_bit2 = protect_code[2];
    wire protect_code_bit1 = protect_code[1];
    wire protect_code_bit0 = protect_code[0];
    wire [2:0] density = ctrl[`SFWP_CTRL_DENS_MSB:`SFWP_CTRL_DENS_LSB];
    wire alt_map = ctrl[`SFWP_CTRL_ALT_BIT];
    wire option_c = ctrl[`SFWP_CTRL_OPTC_BIT];

    // Protect pin only acts while the third line is not a data line
    wire wp_pin_low = !quad_enable && !third_data_line_in;
    wire status_locked = status_write_disable && wp_pin_low;
    wire hold_active = !quad_enable && !fourth_data_line_in;

    function [2:0] kind_of;
        input [7:0] op;
        input [2:0] dens;
        input optc;
        begin
            case (op)
                `SFWP_OP_PP, `SFWP_OP_PPQ_A, `SFWP_OP_PPQ_B: kind_of = `SFWP_KIND_PROG;
                `SFWP_OP_SER_A, `SFWP_OP_SER_B: kind_of = `SFWP_KIND_SECT;
                `SFWP_OP_BER32: kind_of = `SFWP_KIND_BLK32;
                `SFWP_OP_BER64: begin
                    if ((dens == `SFWP_DENS_1M && optc) || dens == `SFWP_DENS_512K ||
                        dens == `SFWP_DENS_256K)
                        kind_of = `SFWP_KIND_BLK32;
                    else
                        kind_of = `SFWP_KIND_BLK64;
                end
                `SFWP_OP_CER_A, `SFWP_OP_CER_B: kind_of = `SFWP_KIND_CHIP;
                default: kind_of = `SFWP_KIND_NONE;
            endcase
        end
    endfunction

    function [2:0] block_of;
        input [23:0] a;
        input [2:0] dens;
        begin
            case (dens)
                `SFWP_DENS_4M: block_of = a[18:16];
                `SFWP_DENS_2M: block_of = {1'b0, a[17:16]};
                `SFWP_DENS_1M: block_of = {2'b00, a[16]};
                default: block_of = 3'h0;
            endcase
        end
    endfunction

    wire [2:0] cur_kind = kind_of(cmd, density, option_c);
    wire [2:0] tgt_blk = block_of(addr, density);
    wire tgt_protected = (cur_kind == `SFWP_KIND_CHIP) ? (|prot_mask) : prot_mask[tgt_blk];
    wire [2:0] need_bytes = (cur_kind == `SFWP_KIND_PROG) ? `SFWP_PROG_BYTES :
                            (cur_kind == `SFWP_KIND_CHIP) ? 3'h1 : `SFWP_ADDR_BYTES;
    wire frame_ok = rx_frame_end && rx_aligned && (state == S_BODY);
    wire is_write_op = (cur_kind != `SFWP_KIND_NONE) && (byte_cnt >= need_bytes);
    wire wstat_ok = (cmd == `SFWP_OP_WSR) && (byte_cnt >= `SFWP_WSR_BYTES);
    wire av_take = !avs_waitrequest_out && (avs_read_in || avs_write_in);
    wire av_wr = !avs_waitrequest_out && avs_write_in;

    sfwp_spi_rx u_rx (
        .ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .cs_n_in(spi_cs_n_in),
        .sck_in(spi_sck_in),
        .si_in(spi_si_in),
        .pause_in(hold_active),
        .byte_valid_out(rx_byte_valid),
        .byte_out(rx_byte),
        .frame_end_out(rx_frame_end),
        .aligned_out(rx_aligned),
        .sck_fall_out(rx_sck_fall)
    );

    sfwp_prot_map u_map (
        .ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .code_in({protect_code_bit3, protect_code_bit2, protect_code_bit1, protect_code_bit0}),
        .density_in(density),
        .alt_map_in(alt_map),
        .mask_out(prot_mask)
    );

    // Frame sequencing: command byte, then address and data bytes
    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state <= S_IDLE;
            byte_cnt <= 3'h0;
            cmd <= 8'h00;
            addr <= 24'h000000;
            wdata <= 8'h00;
        end else if (rx_frame_end) begin
            state <= S_IDLE;
            byte_cnt <= 3'h0;
        end else if (rx_byte_valid) begin
            if (byte_cnt != 3'h7) begin
                byte_cnt <= byte_cnt + 3'h1;
            end
            case (state)
                S_IDLE: begin
                    cmd <= rx_byte;
                    if (rx_byte == `SFWP_OP_RDSR)
                        state <= S_RDSR;
                    else if (wip)
                        state <= S_SKIP;
                    else
                        state <= S_BODY;
                end
                S_BODY: begin
                    if (byte_cnt == 3'h1) begin
                        wdata <= rx_byte;
                    end
                    if (byte_cnt >= 3'h1 && byte_cnt <= 3'h3) begin
                        addr <= {addr[15:0], rx_byte};
                    end
                end
                S_RDSR: state <= S_RDSR;
                S_SKIP: state <= S_SKIP;
                default: state <= S_IDLE;
            endcase
        end
    end

    // Status read-back shifts out on SCK falling edges
    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            so_shift <= 8'h00;
            spi_so_out <= 1'b0;
            spi_so_oe_n_out <= 1'b1;
        end else begin
            spi_so_oe_n_out <= !(state == S_RDSR && !spi_cs_n_in);
            if (state == S_IDLE && rx_byte_valid && rx_byte == `SFWP_OP_RDSR) begin
                so_shift <= status_byte;
            end else if (state == S_RDSR && rx_sck_fall) begin
                spi_so_out <= so_shift[7];
                if (so_shift[6:0] == 7'h00 && rx_byte_valid) begin
                    so_shift <= status_byte;
                end else begin
                    so_shift <= {so_shift[6:0], so_shift[7]};
                end
            end else if (state == S_RDSR && rx_byte_valid) begin
                so_shift <= status_byte;
            end
        end
    end

    // Write enable latch and non-volatile status bits
    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            nv_bits <= `SFWP_NV_RESET;
            write_enable_latch <= 1'b0;
            wip <= 1'b0;
        end else begin
            wip <= op_busy_in || op_start_out;
            if (frame_ok) begin
                if (cmd == `SFWP_OP_WEN) begin
                    write_enable_latch <= 1'b1;
                end else if (cmd == `SFWP_OP_WRDI) begin
                    write_enable_latch <= 1'b0;
                end else if (wstat_ok && write_enable_latch && !status_locked) begin
                    nv_bits <= wdata[7:2];
                    write_enable_latch <= 1'b0;
                end else if (is_write_op && write_enable_latch) begin
                    write_enable_latch <= 1'b0;
                end
            end
        end
    end

    // Program and erase hand-off or refusal
    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            op_start_out <= 1'b0;
            op_reject_out <= 1'b0;
            op_kind_out <= `SFWP_KIND_NONE;
            op_addr_out <= 24'h000000;
            last_addr <= 24'h000000;
            last_kind <= `SFWP_KIND_NONE;
            last_rej <= 1'b0;
        end else begin
            op_start_out <= 1'b0;
            op_reject_out <= 1'b0;
            if (frame_ok && is_write_op && write_enable_latch) begin
                last_addr <= addr;
                last_kind <= cur_kind;
                last_rej <= tgt_protected;
                if (tgt_protected) begin
                    op_reject_out <= 1'b1;
                end else begin
                    op_start_out <= 1'b1;
                    op_kind_out <= cur_kind;
                    op_addr_out <= addr;
                end
            end
        end
    end

    // Pin function indication
    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            quad_enable_out <= 1'b0;
            wp_function_out <= 1'b1;
            hold_function_out <= 1'b1;
        end else begin
            quad_enable_out <= quad_enable;
            wp_function_out <= !quad_enable;
            hold_function_out <= !quad_enable;
        end
    end

    // Register read mux
    always @* begin
        case (avs_address_in)
            `SFWP_ADDR_CTRL: next_readdata = {27'h0000000, ctrl};
            `SFWP_ADDR_STATUS: next_readdata = {22'h000000, status_locked, third_data_line_in, status_byte};
            `SFWP_ADDR_LASTOP: next_readdata = {4'h0, last_rej, last_kind, last_addr};
            `SFWP_ADDR_PROTMASK: next_readdata = {24'h000000, prot_mask};
            default: next_readdata = 32'h00000000;
        endcase
    end

    // Avalon-MM slave: one wait cycle, then the access completes
    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out <= 32'h00000000;
            ctrl <= `SFWP_CTRL_RESET;
        end else begin
            if (avs_waitrequest_out) begin
                if (avs_read_in || avs_write_in) begin
                    avs_waitrequest_out <= 1'b0;
                    avs_readdata_out <= next_readdata;
                end
            end else begin
                avs_waitrequest_out <= 1'b1;
            end
            if (av_wr && avs_address_in == `SFWP_ADDR_CTRL && avs_byteenable_in[0]) begin
                ctrl <= avs_writedata_in[4:0];
            end
            if (av_take && !avs_read_in) begin
                avs_readdata_out <= 32'h00000000;
            end
        end
    end
endmodule // sfwp_write_protect

// >>> verification/sfwp_host_model.sv
// SPI host model that frames instruction bytes for the write-protect block.
// Assumes a free-running ref_clk_in; sck idles low and moves only inside frames.
`timescale 1ns/1ps
module sfwp_host_model (
    input wire ref_clk_in,
    output reg cs_n_out,
    output reg sck_out,
    output reg si_out
);
    integer j;
    initial begin
        cs_n_out = 1'b1;
        sck_out = 1'b0;
        si_out = 1'b0;
    end
    // Sends n bytes, MSB first, each sck phase at least 2 clocks
    task frame(input [39:0] b, input integer n);
        begin
            @(posedge ref_clk_in) cs_n_out <= 1'b0;
            for (j = n * 8 - 1; j >= 0; j = j - 1) begin
                @(posedge ref_clk_in) si_out <= b[j];
                repeat (2) @(posedge ref_clk_in);
                sck_out <= 1'b1;
                repeat (2) @(posedge ref_clk_in);
                sck_out <= 1'b0;
            end
            repeat (2) @(posedge ref_clk_in);
            cs_n_out <= 1'b1;
            si_out <= ~si_out;
            repeat (6) @(posedge ref_clk_in);
        end
    endtask
    // Write enable first, then the status write
    task write_status(input [7:0] s);
        begin
            frame(40'h06, 1);
            frame({8'h01, s}, 2);
        end
    endtask
endmodule // sfwp_host_model

// >>> verification/sfwp_write_protect_bench.sv
// Self-checking bench for the write-protect block with an SPI host model.
// Assumes sfwp_regs.vh on the include path; Avalon master and pins driven here.
`timescale 1ns/1ps
`include "sfwp_regs.vh"
module sfwp_write_protect_bench;
    localparam [71:0] OPS = {8'h02, 8'h32, 8'h38, 8'hd7, 8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60};
    reg clk, rst_n, rd, wr, third, fourth, busy, rej;
    reg [3:0] addr, be;
    reg [31:0] wd, q;
    reg [23:0] ad;
    reg [7:0] op, sh;
    wire [31:0] rdata;
    wire [23:0] opa;
    wire [2:0] kind;
    wire waitreq, cs_n, sck, si, start, reject, quad, wpf, holdf, so, oe_n;
    integer failures, total_checks, seed, n_st, n_rj, s0, r0, i, c, d, k, ln;
    sfwp_host_model host_i (.ref_clk_in(clk), .cs_n_out(cs_n), .sck_out(sck), .si_out(si));
    sfwp_write_protect sfwp_write_protect_i (.ref_clk_in(clk), .reset_n_in(rst_n), .avs_address_in(addr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(be),
        .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq), .spi_cs_n_in(cs_n), .spi_sck_in(sck),
        .spi_si_in(si), .spi_so_out(so), .spi_so_oe_n_out(oe_n), .third_data_line_in(third),
        .fourth_data_line_in(fourth), .op_busy_in(busy), .op_start_out(start), .op_reject_out(reject),
        .op_kind_out(kind), .op_addr_out(opa), .quad_enable_out(quad), .wp_function_out(wpf),
        .hold_function_out(holdf));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        if (start === 1'b1) n_st <= n_st + 1;
        if (reject === 1'b1) n_rj <= n_rj + 1;
    end
    always @(posedge sck) sh <= {sh[6:0], so | oe_n};
    task check(input [31:0] seen, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task av(input w, input [3:0] a, input [31:0] dd, output [31:0] qq);
        integer t;
        begin
            @(posedge clk);
            rd <= !w;
            wr <= w;
            addr <= a;
            wd <= dd;
            t = 0;
            @(posedge clk);
            while (waitreq !== 1'b0 && t < 20) begin
                @(posedge clk);
                t = t + 1;
            end
            qq = rdata;
            rd <= 1'b0;
            wr <= 1'b0;
            if (t >= 20) failures = failures + 1;
        end
    endtask
    task pulse_reset;
        begin
            rst_n <= 1'b0;
            repeat (3) @(posedge clk);
            rst_n <= 1'b1;
        end
    endtask
    task status(input [7:0] exp);
        begin
            av(0, `SFWP_ADDR_STATUS, 0, q);
            check(q[7:0], exp);
        end
    endtask
    // Blocks protected for a code, density and map choice
    function [7:0] exp_mask(input [3:0] c, input [2:0] d, input al);
        integer n, p, k, top;
        begin
            n = d == 0 ? 8 : d == 1 ? 4 : d == 2 ? 2 : 1;
            p = d == 0 ? 5 : d == 1 ? 3 : d == 2 ? 1 : 0;
            k = n;
            top = 1;
            if (c == 0 || (al && c == 15)) k = 0;
            else if (c <= p) k = d == 0 ? (20'h76421 >> (4 * (c - 1))) & 15 : c;
            else if (!al && c >= 9 && c <= 8 + p) begin
                top = 0;
                k = d == 0 ? (20'h76421 >> (4 * (c - 9))) & 15 : c - 8;
            end else if (al && c >= 15 - p) begin
                top = 0;
                k = d == 0 ? (20'h76421 >> (4 * (14 - c))) & 15 : 15 - c;
            end
            exp_mask = top ? ((1 << k) - 1) << (n - k) : (1 << k) - 1;
        end
    endfunction
    task finish_test;
        begin
            $display("checks %0d, mismatches %0d", total_checks, failures);
            if (failures == 0 && total_checks > 0) $display("NO MISMATCHES");
            else $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    initial begin
        #2000000;
        failures = failures + 1;
        finish_test;
    end
    initial begin
        failures = 0;
        total_checks = 0;
        seed = 32'h89b83da6;
        n_st = 0;
        n_rj = 0;
        rst_n = 1'b0;
        {rd, wr, addr, wd, be} = 4'hf;
        third = 1'b0;
        fourth = 1'b1;
        busy = 1'b0;
        pulse_reset;
        status(8'h00);
        for (c = 0; c < 16; c = c + 1) begin
            host_i.write_status({2'b00, c[3:0], 2'b00});
            status({2'b00, c[3:0], 2'b00});
            for (d = 0; d < 10; d = d + 1) begin
                av(1, `SFWP_ADDR_CTRL, ((d & 1) << 3) | (d >> 1), q);
                av(0, `SFWP_ADDR_PROTMASK, 0, q);
                check(q[7:0], exp_mask(c, d >> 1, d & 1));
            end
        end
        be <= 4'he;
        av(1, `SFWP_ADDR_CTRL, 32'h1f, q);
        be <= 4'hf;
        av(0, `SFWP_ADDR_CTRL, 0, q);
        check(q, 12);
        av(0, 4'h2, 0, q);
        check(q, 0);
        $display("protect map test done");
        av(1, `SFWP_ADDR_CTRL, 0, q);
        host_i.write_status(8'h8c);
        status(8'h8c);
        host_i.write_status(8'h00);
        status(8'h8e);
        third <= 1'b1;
        host_i.write_status(8'h00);
        status(8'h00);
        third <= 1'b0;
        host_i.write_status(8'h40);
        check({quad, wpf, holdf}, 3'b100);
        host_i.write_status(8'hc0);
        host_i.write_status(8'h00);
        status(8'h00);
        check({quad, wpf, holdf}, 3'b011);
        $display("status lock test done");
        host_i.write_status(8'h04);
        for (i = 0; i < 9; i = i + 1) begin
            op = OPS[71 - 8 * i -: 8];
            k = i < 3 ? 1 : i < 5 ? 2 : i == 5 ? 3 : i == 6 ? 4 : 5;
            ln = i < 3 ? 5 : i < 7 ? 4 : 1;
            ad = $random(seed) & 24'h07ffff;
            if (i & 1) ad[18:16] = 3'h7;
            rej = k == 5 || ad[18:16] == 3'h7;
            s0 = n_st;
            r0 = n_rj;
            host_i.frame(40'h06, 1);
            host_i.frame(ln == 5 ? {op, ad, 8'h5a} : ln == 4 ? {op, ad} : op, ln);
            check(n_rj - r0, rej);
            check(n_st - s0, !rej);
            if (!rej) check(kind, k);
            if (!rej) check(opa, ad);
            status(8'h04);
        end
        s0 = n_st + n_rj;
        host_i.frame({8'hd8, 24'h000000}, 4);
        check(n_st + n_rj - s0, 0);
        busy <= 1'b1;
        host_i.frame(40'h06, 1);
        status(8'h05);
        host_i.frame(40'h0500, 2);
        check(sh, 5);
        busy <= 1'b0;
        fourth <= 1'b0;
        host_i.frame(40'h06, 1);
        fourth <= 1'b1;
        status(8'h04);
        $display("program erase test done");
        av(1, `SFWP_ADDR_CTRL, 32'h12, q);
        host_i.write_status(8'h00);
        host_i.frame(40'h06, 1);
        host_i.frame({8'hd8, 24'h010000}, 4);
        check(kind, 3);
        host_i.frame(40'h06, 1);
        host_i.frame({8'h52, 24'h008000}, 4);
        check({kind, opa}, {3'h3, 24'h008000});
        host_i.write_status(8'h7c);
        pulse_reset;
        status(8'h00);
        $display("option and reset test done");
        finish_test;
    end
endmodule // sfwp_write_protect_bench

// >>> verification/sfwp_write_protect_sva.sv
// Port checker for the write-protect block.
// Assumes one clock domain and binding to sfwp_write_protect.
`timescale 1ns/1ps
module sfwp_write_protect_sva (
    input wire ref_clk_in,
    input wire reset_n_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire avs_waitrequest_out,
    input wire spi_cs_n_in,
    input wire spi_so_oe_n_out,
    input wire op_busy_in,
    input wire op_start_out,
    input wire op_reject_out,
    input wire [23:0] op_addr_out,
    input wire quad_enable_out,
    input wire wp_function_out,
    input wire hold_function_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);
    a_wait_answer: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
        else $error("access not answered after one wait");
    a_wait_single: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("waitrequest low too long");
    a_start_once: assert property (op_start_out |=> !op_start_out)
        else $error("start pulse too long");
    a_reject_once: assert property (op_reject_out |=> !op_reject_out)
        else $error("reject pulse too long");
    a_op_exclusive: assert property (!(op_start_out && op_reject_out))
        else $error("start and reject together");
    a_addr_held: assert property ($changed(op_addr_out) |-> op_start_out || op_reject_out)
        else $error("address changed without operation");
    a_wp_quad: assert property (wp_function_out == !quad_enable_out)
        else $error("protect pin function wrong");
    a_hold_quad: assert property (hold_function_out == !quad_enable_out)
        else $error("hold pin function wrong");
    a_busy_quiet: assert property (op_busy_in && $past(op_busy_in) && $past(op_busy_in, 2)
        |-> !op_start_out && !op_reject_out)
        else $error("operation while busy");
    a_so_release: assert property (spi_cs_n_in && $past(spi_cs_n_in) |-> spi_so_oe_n_out)
        else $error("output driven while deselected");
endmodule // sfwp_write_protect_sva

bind sfwp_write_protect sfwp_write_protect_sva sfwp_write_protect_sva_i (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_waitrequest_out(avs_waitrequest_out), .spi_cs_n_in(spi_cs_n_in),
    .spi_so_oe_n_out(spi_so_oe_n_out), .op_busy_in(op_busy_in), .op_start_out(op_start_out),
    .op_reject_out(op_reject_out), .op_addr_out(op_addr_out), .quad_enable_out(quad_enable_out),
    .wp_function_out(wp_function_out), .hold_function_out(hold_function_out));
